// [hdl/serial_regs_core.sv]
/*
 Register file and prioritised interrupt logic of the serial port.
 Assumes the shifter datapath supplies receive status, a character tick and
 the transmit-empty level, and takes back the holding byte and FIFO strobes.
*/
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module serial_regs_core
	import serial_regs_pkg::*;
#(
	parameter int          PORT_EN_W     = 1,   // 4 on the infrared instance
	parameter int          TIMEOUT_CHARS = 4,
	parameter logic [7:0]  MODEM_RST     = 8'h00 // Upper nibble follows pins
) (
	input  wire logic                 SYS_CLK_I,
	input  wire logic                 RESET_I,
	input  wire logic [7:0]           ADDR_I,
	input  wire logic [7:0]           WDATA_I,
	input  wire logic                 WR_I,
	input  wire logic                 RD_I,
	output logic      [7:0]           RDATA_O,
	input  wire logic [7:0]           RX_DATA_I,
	input  wire logic [4:0]           RX_LEVEL_I,
	input  wire logic                 RX_PUSH_I,
	input  wire logic                 CHAR_TICK_I,
	input  wire logic                 OVERRUN_I,
	input  wire logic                 PARITY_ERR_I,
	input  wire logic                 FRAMING_ERR_I,
	input  wire logic                 BREAK_I,
	input  wire logic                 TX_EMPTY_I,
	input  wire logic                 TX_IDLE_I,
	input  wire logic [3:0]           MODEM_PINS_I,
	output logic      [7:0]           TX_DATA_O,
	output logic                      TX_LOAD_O,
	output logic                      RX_POP_O,
	output logic                      TX_FIFO_CLEAR_O,
	output logic                      RX_FIFO_CLEAR_O,
	output logic      [15:0]          DIVISOR_O,
	output logic      [7:0]           LINE_CONTROL_O,
	output logic      [2:0]           MODEM_CONTROL_O,
	output logic                      FIFO_MODE_O,
	output logic      [PORT_EN_W-1:0] PORT_ENABLE_O,
	output logic                      SERIAL_IRQ_OUT_O
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	bus_req_type      req;
	rx_stat_type      rxs;
	logic [7:0]       divisor_low_byte_r;
	logic [7:0]       divisor_high_byte_r;
	logic [3:0]       interrupt_enable_r;
	logic [7:0]       line_control_r;
	logic [2:0]       modem_control_r;
	logic [7:0]       scratch_byte_r;
	logic [PORT_EN_W-1:0] port_enable_r;
	logic             fifo_en_r;
	logic [1:0]       rx_threshold_r;

	// Event sources and modem pin sampling
	logic [3:0]       line_err_r;
	logic [3:0]       modem_delta_r;
	logic [3:0]       pins_s1_r;
	logic [3:0]       pins_s2_r;
	logic [3:0]       pins_s3_r;
	logic [3:0]       pins_stable_r;
	logic             pins_settle;
	logic [3:0]       delta_set;
	logic             tx_irq_r;
	logic             tx_empty_d_r;
	logic [7:0]       timeout_cnt_r;
	logic             timeout_r;

	// Interrupt indication and read path
	logic [3:0]       ident_r;
	logic [3:0]       ident_nxt;
	logic [7:0]       rdata_r;
	logic [7:0]       rdata_nxt;

	// Decodes and gated interrupt requests
	logic             dla;
	logic [4:0]       trig;
	logic             rx_avail;
	logic             line_irq;
	logic             rx_irq;
	logic             to_irq;
	logic             tx_irq;
	logic             ms_irq;
	logic             hit_data_rd;
	logic             hit_ident_rd;
	logic [7:0]       line_status;
	logic [7:0]       modem_status;

	// Bundle bus and receive inputs so the logic reads by field
	assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
	assign rxs = '{data: RX_DATA_I, level: RX_LEVEL_I, char_tick: CHAR_TICK_I,
		pushed: RX_PUSH_I, overrun: OVERRUN_I, parity_err: PARITY_ERR_I,
		framing_err: FRAMING_ERR_I, break_det: BREAK_I};

	// Divisor access steers offsets 0 and 4 only
	assign dla = line_control_r[DLA_BIT];
	assign hit_data_rd  = req.rd && req.addr == OFF_DATA && !dla;
	assign hit_ident_rd = req.rd && req.addr == OFF_IDENT;

	// ---------------------------------------------------------------
	// Software-written registers
	// ---------------------------------------------------------------
	// Divisor resets to zero so the baud generator stays stopped
	// until software programs it; enable bits 7:4 read zero
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			divisor_low_byte_r  <= RST_ZERO;
			divisor_high_byte_r <= RST_ZERO;
			interrupt_enable_r  <= 4'h0;
			line_control_r      <= RST_ZERO;
			modem_control_r     <= 3'h0;
			scratch_byte_r      <= RST_ZERO;
			port_enable_r       <= '0;
		end else if (req.wr) begin
			case (req.addr)
				OFF_DATA: begin
					if (dla) divisor_low_byte_r <= req.wdata;
				end
				OFF_ENABLE: begin
					if (dla) divisor_high_byte_r <= req.wdata;
					else interrupt_enable_r <= req.wdata[3:0];
				end
				OFF_LINECTL: line_control_r  <= req.wdata;
				OFF_MODEMCT: modem_control_r <= req.wdata[2:0];
				OFF_SCRATCH: scratch_byte_r  <= req.wdata;
				OFF_PORTEN:  port_enable_r   <= req.wdata[PORT_EN_W-1:0];
				default: ;
			endcase
		end
	end

	// FIFO control: other bits only take effect with bit 0 set
	// Clears are one-cycle pulses; the datapath owns the storage
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			fifo_en_r       <= 1'b0;
			rx_threshold_r  <= 2'h0;
			TX_FIFO_CLEAR_O <= 1'b0;
			RX_FIFO_CLEAR_O <= 1'b0;
		end else if (req.wr && req.addr == OFF_IDENT) begin
			fifo_en_r <= req.wdata[FC_ENABLE_BIT];
			if (req.wdata[FC_ENABLE_BIT])
				rx_threshold_r <= req.wdata[7:6];
			// Mode change or explicit clear empties the FIFOs
			TX_FIFO_CLEAR_O <= (req.wdata[FC_ENABLE_BIT] != fifo_en_r) ||
				(req.wdata[FC_ENABLE_BIT] && req.wdata[FC_TXCLR_BIT]);
			RX_FIFO_CLEAR_O <= (req.wdata[FC_ENABLE_BIT] != fifo_en_r) ||
				(req.wdata[FC_ENABLE_BIT] && req.wdata[FC_RXCLR_BIT]);
		end else begin
			TX_FIFO_CLEAR_O <= 1'b0;
			RX_FIFO_CLEAR_O <= 1'b0;
		end
	end

	// Receive trigger decode
	// Only used in FIFO mode; without FIFOs one byte is enough
	always_comb begin
		case (rx_threshold_r)
			2'h0: trig = TRIG_1;
			2'h1: trig = TRIG_4;
			2'h2: trig = TRIG_8;
			default: trig = TRIG_14;
		endcase
	end

	// ---------------------------------------------------------------
	// Event sources; they update regardless of the enables
	// ---------------------------------------------------------------

	// Line errors stick until line status is read; a new error wins
	// Error pulses last one cycle, so they must be caught here
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I)
			line_err_r <= 4'h0;
		else
			line_err_r <= ((req.rd && req.addr == OFF_LINESTA) ? 4'h0 : line_err_r) |
				{rxs.break_det, rxs.framing_err, rxs.parity_err, rxs.overrun};
	end

	// Modem pins come from outside: three-stage sampling, act when 2 and 3 agree
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			pins_s1_r     <= 4'h0;
			pins_s2_r     <= 4'h0;
			pins_s3_r     <= 4'h0;
			pins_stable_r <= MODEM_RST[7:4];
		end else begin
			pins_s1_r <= MODEM_PINS_I;
			pins_s2_r <= pins_s1_r;
			pins_s3_r <= pins_s2_r;
			if (pins_settle)
				pins_stable_r <= pins_s3_r;
		end
	end

	// A pin caught mid-transition never counts: stages 2 and 3 must agree
	assign pins_settle = (pins_s2_r == pins_s3_r);

	// Per-pin change detect; ring reports only its trailing edge
	generate
		for (genvar b = 0; b < 4; b++) begin : g_delta
			if (b == MS_RING_BIT) begin : g_ring
				assign delta_set[b] = pins_settle && pins_stable_r[b] && !pins_s3_r[b];
			end else begin : g_level
				assign delta_set[b] = pins_settle && (pins_stable_r[b] != pins_s3_r[b]);
			end
		end
	endgenerate

	// Deltas stick until modem status is read; a new change wins
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I)
			modem_delta_r <= 4'h0;
		else
			modem_delta_r <= ((req.rd && req.addr == OFF_MODEMST) ? 4'h0 : modem_delta_r)
				| delta_set;
	end

	// Transmit empty latches on the rising edge, cleared by holding write or ident read
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			tx_irq_r     <= 1'b0;
			tx_empty_d_r <= 1'b1;                                   // Idle level: no false edge
		end else begin
			tx_empty_d_r <= TX_EMPTY_I;
			if (TX_EMPTY_I && !tx_empty_d_r)
				tx_irq_r <= 1'b1;                                       // Set wins
			else if ((req.wr && req.addr == OFF_DATA && !dla) ||
				(hit_ident_rd && ident_r[3:1] == CODE_TXEMPTY && !ident_r[0]))
				tx_irq_r <= 1'b0;
		end
	end

	// Character time-out: count idle character times while data is held
	// The flag holds once reached; a push, a buffer read or an
	// empty FIFO restarts the count
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			timeout_cnt_r <= 8'h00;
			timeout_r     <= 1'b0;
		end else if (!fifo_en_r || rxs.level == 5'h00 || rxs.pushed || hit_data_rd) begin
			timeout_cnt_r <= 8'h00;
			timeout_r     <= 1'b0;
		end else if (rxs.char_tick) begin
			if (timeout_cnt_r == 8'(TIMEOUT_CHARS - 1))
				timeout_r <= 1'b1;
			else
				timeout_cnt_r <= timeout_cnt_r + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Gating and priority
	// ---------------------------------------------------------------
	// Enables gate the report only; sources keep latching, so a
	// late enable shows an event that is already pending
	assign rx_avail = fifo_en_r ? (rxs.level >= trig) : (rxs.level != 5'h00);
	assign line_irq = interrupt_enable_r[EN_LINE_BIT]   && |line_err_r;
	assign rx_irq   = interrupt_enable_r[EN_RXDATA_BIT] && rx_avail;
	assign to_irq   = interrupt_enable_r[EN_RXDATA_BIT] && timeout_r;
	assign tx_irq   = interrupt_enable_r[EN_TXEMPT_BIT] && tx_irq_r;
	assign ms_irq   = interrupt_enable_r[EN_MODEM_BIT]  && |modem_delta_r;

	// Received data ranks above time-out within level two
	always_comb begin
		if (line_irq)      ident_nxt = {CODE_LINE, 1'b0};
		else if (rx_irq)   ident_nxt = {CODE_RXDATA, 1'b0};
		else if (to_irq)   ident_nxt = {CODE_TIMEOUT, 1'b0};
		else if (tx_irq)   ident_nxt = {CODE_TXEMPTY, 1'b0};
		else if (ms_irq)   ident_nxt = {CODE_MODEM, 1'b0};
		else               ident_nxt = 4'h1;
	end

	// Indication frozen during an ident read; sources still latch meanwhile
	// Software never sees a code change under its own read
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I)
			ident_r <= 4'h1;
		else if (!hit_ident_rd)
			ident_r <= ident_nxt;
	end

	// Output follows the pending indication one cycle late; it uses
	// the next value so a frozen read does not delay a new interrupt
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I)
			SERIAL_IRQ_OUT_O <= 1'b0;
		else
			SERIAL_IRQ_OUT_O <= !ident_nxt[0];
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Status words are built live; only the read data are registered
	assign line_status  = {rxs.level == 5'h00 ? 1'b0 : |line_err_r, TX_IDLE_I,
		TX_EMPTY_I, line_err_r[3:0], rxs.level != 5'h00};
	assign modem_status = {pins_stable_r, modem_delta_r};

	always_comb begin
		rdata_nxt = 8'h00;
		case (req.addr)
			OFF_DATA:    rdata_nxt = dla ? divisor_low_byte_r : rxs.data;
			OFF_ENABLE:  rdata_nxt = dla ? divisor_high_byte_r : {4'h0, interrupt_enable_r};
			OFF_IDENT:   rdata_nxt = {{2{fifo_en_r}}, 2'b00, ident_r};
			OFF_LINECTL: rdata_nxt = line_control_r;
			OFF_MODEMCT: rdata_nxt = {5'h00, modem_control_r};
			OFF_LINESTA: rdata_nxt = line_status;
			OFF_MODEMST: rdata_nxt = modem_status;
			OFF_SCRATCH: rdata_nxt = scratch_byte_r;
			OFF_PORTEN:  rdata_nxt = 8'(port_enable_r);
			default:     rdata_nxt = 8'h00;
		endcase
	end

	// Read data valid the cycle after the strobe only
	// Zero otherwise, so a shared read bus sees no stale byte
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I)
			rdata_r <= 8'h00;
		else
			rdata_r <= req.rd ? rdata_nxt : 8'h00;
	end
	assign RDATA_O = rdata_r;

	// Datapath strobes
	// One cycle each; a held strobe would pop or load twice
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			TX_DATA_O <= 8'h00;
			TX_LOAD_O <= 1'b0;
			RX_POP_O  <= 1'b0;
		end else begin
			TX_LOAD_O <= req.wr && req.addr == OFF_DATA && !dla;
			if (req.wr && req.addr == OFF_DATA && !dla)
				TX_DATA_O <= req.wdata;
			RX_POP_O <= hit_data_rd;
		end
	end

	// Configuration outputs
	// Mirrored one cycle late so every output leaves a flip-flop
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			DIVISOR_O       <= 16'h0000;
			LINE_CONTROL_O  <= 8'h00;
			MODEM_CONTROL_O <= 3'h0;
			FIFO_MODE_O     <= 1'b0;
			PORT_ENABLE_O   <= '0;
		end else begin
			DIVISOR_O       <= {divisor_high_byte_r, divisor_low_byte_r};
			LINE_CONTROL_O  <= line_control_r;
			MODEM_CONTROL_O <= modem_control_r;
			FIFO_MODE_O     <= fifo_en_r;
			PORT_ENABLE_O   <= port_enable_r;
		end
	end

endmodule // serial_regs_core

// [hdl/serial_regs_pkg.sv]
/*
 Register map, field positions, reset values and shared types of the serial
 port register and interrupt core.
 Assumes a single 100 MHz clock and a synchronous active-high reset.
*/
// Function
// - Divisor access clear: offset 0 reads received byte, writes transmit holding.
// - Divisor access set: offsets 0 and 4 reach divisor low and high bytes.
// - Enable bits 3,2,1 gate modem, line status and transmit-empty interrupts.
// - Enable bit 0 gates received-data and, in FIFO mode, time-out interrupts.
// - Any enabled source alone drives the interrupt output.
// - Disabled sources are neither reported pending nor drive the output.
// - Line and modem status keep updating whatever the enables say.
// - Priority: line status, received data, transmit empty, modem status.
// - Reported source is held steady while identification is being read.
// - New events during that read are recorded; indication changes afterward.
// - Identification bits 7:6 read ones when FIFOs enabled, else zero.
// - Identification bits 5:4 always read zero.
// - Bit 3 zero without FIFOs; set with bit 2 on character time-out.
// - Line status code 011: overrun/parity/framing/break; cleared by status read.
// - Received data code 010: data or trigger; cleared by read or below trigger.
// - Time-out code 110: held data idle four characters; cleared by buffer read.
// - Transmit empty code 001: cleared by identification read or holding write.
// - Modem code 000: status line change; cleared by modem status read.
// - Identification bit 0 is zero while pending, one when nothing pending.
// - Offset 8 reads identification and writes FIFO control.
// - Port enable is 1 bit wide, 4 bits on the infrared-capable instance.
// - Divisor access is line control bit 7.
// - FIFO control bit 0 enables FIFOs; clearing empties; other bits need it set.
// - FIFO control bits 7:6 pick receive trigger 1, 4, 8 or 14 bytes.
package serial_regs_pkg;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_DATA    = 8'h00;
	localparam logic [7:0] OFF_ENABLE  = 8'h04;
	localparam logic [7:0] OFF_IDENT   = 8'h08;
	localparam logic [7:0] OFF_LINECTL = 8'h0c;
	localparam logic [7:0] OFF_MODEMCT = 8'h10;
	localparam logic [7:0] OFF_LINESTA = 8'h14;
	localparam logic [7:0] OFF_MODEMST = 8'h18;
	localparam logic [7:0] OFF_SCRATCH = 8'h1c;
	localparam logic [7:0] OFF_PORTEN  = 8'h30;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int DLA_BIT       = 7;
	localparam int EN_RXDATA_BIT = 0;
	localparam int EN_TXEMPT_BIT = 1;
	localparam int EN_LINE_BIT   = 2;
	localparam int EN_MODEM_BIT  = 3;
	localparam int FC_ENABLE_BIT = 0;
	localparam int FC_RXCLR_BIT  = 1;
	localparam int FC_TXCLR_BIT  = 2;
	localparam int MS_RING_BIT   = 2;

	// ---------------------------------------------------------------
	// Reset values and codes
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_LINESTA  = 8'h60;
	localparam logic [2:0] CODE_LINE    = 3'h3;
	localparam logic [2:0] CODE_RXDATA  = 3'h2;
	localparam logic [2:0] CODE_TIMEOUT = 3'h6;
	localparam logic [2:0] CODE_TXEMPTY = 3'h1;
	localparam logic [2:0] CODE_MODEM   = 3'h0;
	localparam logic [4:0] TRIG_1       = 5'h01;
	localparam logic [4:0] TRIG_4       = 5'h04;
	localparam logic [4:0] TRIG_8       = 5'h08;
	localparam logic [4:0] TRIG_14      = 5'h0e;

	// Register bus request bundle
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_type;

	// Receive-side status from the datapath
	typedef struct packed {
		logic [7:0] data;
		logic [4:0] level;
		logic       char_tick;
		logic       pushed;
		logic       overrun;
		logic       parity_err;
		logic       framing_err;
		logic       break_det;
	} rx_stat_type;

endpackage

// [testbench/serial_datapath_model.sv]
/*
 Behavioural shifter datapath facing the register core.
 Assumes the bench requests pushes; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module serial_datapath_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       push_i,
	input  wire logic [7:0] push_data_i,
	input  wire logic       tx_load_i,
	input  wire logic       rx_pop_i,
	input  wire logic       rx_clear_i,
	output logic      [7:0] rx_data_o,
	output logic      [4:0] rx_level_o,
	output logic            rx_push_o,
	output logic            char_tick_o,
	output logic            tx_empty_o
);
	// ---------------------------------------------------------------
	// Receive and transmit sides
	// ---------------------------------------------------------------
	logic [2:0] tick_r;
	logic [2:0] tx_busy_r;
	// Fill count; a popped head is inverted so stale data is never echoed
	always_ff @(posedge clk_i) begin
		rx_push_o <= push_i && !rst_i;
		if (rst_i || rx_clear_i) begin
			rx_level_o <= 5'h00;
			rx_data_o <= 8'h00;
		end else if (push_i) begin
			rx_level_o <= rx_level_o + 5'h01;
			rx_data_o <= push_data_i;
		end else if (rx_pop_i && rx_level_o != 5'h00) begin
			rx_level_o <= rx_level_o - 5'h01;
			rx_data_o <= ~rx_data_o;
		end
	end
	// Character time shortened to 8 cycles to keep time-outs brief
	always_ff @(posedge clk_i) begin
		tick_r <= rst_i ? 3'h0 : tick_r + 3'h1;
		char_tick_o <= (tick_r == 3'h7);
	end
	// A loaded byte occupies the holding register for 6 cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) tx_busy_r <= 3'h0;
		else if (tx_load_i) tx_busy_r <= 3'h6;
		else if (tx_busy_r != 3'h0) tx_busy_r <= tx_busy_r - 3'h1;
	end
	assign tx_empty_o = (tx_busy_r == 3'h0);
endmodule // serial_datapath_model

// [testbench/serial_regs_sva.sv]
/*
 Port-level checks of the serial register and interrupt core.
 Assumes one clock and a synchronous active-high reset; bound below.
*/
`timescale 1ns/1ps
module serial_regs_sva
	import serial_regs_pkg::*;
(
	input wire logic        SYS_CLK_I,
	input wire logic        RESET_I,
	input wire logic [7:0]  ADDR_I,
	input wire logic [7:0]  WDATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [7:0]  RDATA_O,
	input wire logic [7:0]  TX_DATA_O,
	input wire logic        TX_LOAD_O,
	input wire logic        RX_POP_O,
	input wire logic [15:0] DIVISOR_O,
	input wire logic [7:0]  LINE_CONTROL_O,
	input wire logic        FIFO_MODE_O,
	input wire logic        SERIAL_IRQ_OUT_O
);
	// ---------------------------------------------------------------
	// Bus sequences
	// ---------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);
	sequence ident_rd_s; RD_I && ADDR_I == OFF_IDENT; endsequence
	sequence data_wr_s; WR_I && ADDR_I == OFF_DATA; endsequence
	sequence high_wr_s; WR_I && ADDR_I == OFF_ENABLE; endsequence
	sequence data_rd_s; RD_I && ADDR_I == OFF_DATA && !LINE_CONTROL_O[DLA_BIT]; endsequence
	// Mirrored line control lags one cycle behind a write to it
	sequence lcr_calm_s; !$past(WR_I && ADDR_I == OFF_LINECTL); endsequence

	irq_pending_match_a: assert property (
		ident_rd_s |=> RDATA_O[0] == !$past(SERIAL_IRQ_OUT_O))
		else $error("interrupt output disagrees with pending bit");
	ident_zero_bits_a: assert property (
		ident_rd_s |=> RDATA_O[5:4] == 2'b00)
		else $error("identification bits 5:4 not zero");
	fifo_flag_bits_a: assert property (
		ident_rd_s |=> RDATA_O[7:6] == {2{$past(FIFO_MODE_O)}})
		else $error("identification bits 7:6 wrong for FIFO mode");
	timeout_code_a: assert property (
		ident_rd_s |=> !RDATA_O[3] || (RDATA_O[2] && $past(FIFO_MODE_O)))
		else $error("identification bit 3 set outside a time-out");
	holding_load_a: assert property (
		data_wr_s ##0 lcr_calm_s ##0 !LINE_CONTROL_O[DLA_BIT]
			|=> TX_LOAD_O && TX_DATA_O == $past(WDATA_I))
		else $error("holding byte not loaded");
	divisor_low_a: assert property (
		data_wr_s ##0 lcr_calm_s ##0 LINE_CONTROL_O[DLA_BIT]
			|=> !TX_LOAD_O ##1 DIVISOR_O[7:0] == $past(WDATA_I, 2))
		else $error("divisor low byte not written");
	divisor_high_a: assert property (
		high_wr_s ##0 lcr_calm_s ##0 LINE_CONTROL_O[DLA_BIT]
			|=> ##1 DIVISOR_O[15:8] == $past(WDATA_I, 2))
		else $error("divisor high byte not written");
	buffer_pop_a: assert property (
		data_rd_s ##0 lcr_calm_s |=> RX_POP_O)
		else $error("buffer read did not pop");
endmodule // serial_regs_sva

bind serial_regs_core serial_regs_sva sva_u (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.TX_DATA_O(TX_DATA_O), .TX_LOAD_O(TX_LOAD_O), .RX_POP_O(RX_POP_O),
	.DIVISOR_O(DIVISOR_O), .LINE_CONTROL_O(LINE_CONTROL_O), .FIFO_MODE_O(FIFO_MODE_O),
	.SERIAL_IRQ_OUT_O(SERIAL_IRQ_OUT_O));

// [testbench/tb_top.sv]
/*
 Self-checking bench of the serial register core with a datapath model.
 Assumes 100 MHz clock; time-out shortened to 2 character times.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fails++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top;
	import serial_regs_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, push = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, push_data = 8'h00;
	logic [3:0]  err = 4'h0, pins = 4'h0;
	logic [7:0]  rdata, rx_data, tx_data, line_control, rb;
	logic [4:0]  rx_level;
	logic [15:0] divisor, dv;
	logic [2:0]  modem_control;
	logic        rx_push, tick, tx_empty, tx_load, rx_pop, tx_clr, rx_clr;
	logic        fifo_mode, port_en, irq;
	int          seed, fails = 0, tests_run = 0;

	initial forever #5 clk = ~clk;

	serial_regs_core #(.TIMEOUT_CHARS(2)) dut_u (.SYS_CLK_I(clk), .RESET_I(rst),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.RX_DATA_I(rx_data), .RX_LEVEL_I(rx_level), .RX_PUSH_I(rx_push),
		.CHAR_TICK_I(tick), .OVERRUN_I(err[0]), .PARITY_ERR_I(err[1]),
		.FRAMING_ERR_I(err[2]), .BREAK_I(err[3]), .TX_EMPTY_I(tx_empty),
		.TX_IDLE_I(tx_empty), .MODEM_PINS_I(pins), .TX_DATA_O(tx_data),
		.TX_LOAD_O(tx_load), .RX_POP_O(rx_pop), .TX_FIFO_CLEAR_O(tx_clr),
		.RX_FIFO_CLEAR_O(rx_clr), .DIVISOR_O(divisor), .LINE_CONTROL_O(line_control),
		.MODEM_CONTROL_O(modem_control), .FIFO_MODE_O(fifo_mode), .PORT_ENABLE_O(port_en),
		.SERIAL_IRQ_OUT_O(irq));
	serial_datapath_model far_u (.clk_i(clk), .rst_i(rst), .push_i(push),
		.push_data_i(push_data), .tx_load_i(tx_load), .rx_pop_i(rx_pop),
		.rx_clear_i(rx_clr), .rx_data_o(rx_data), .rx_level_o(rx_level),
		.rx_push_o(rx_push), .char_tick_o(tick), .tx_empty_o(tx_empty));

	// ---------------------------------------------------------------
	// Bus tasks and expectations
	// ---------------------------------------------------------------
	function automatic logic [7:0] ident_val(input logic fifo, input logic [2:0] code,
		input logic pend);
		return {{2{fifo}}, 2'b00, code, ~pend};
	endfunction
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	endtask
	task automatic pulse(input logic [3:0] e, input logic p, input logic [7:0] d);
		@(posedge clk);
		err <= e;
		push <= p;
		push_data <= d;
		@(posedge clk);
		err <= 4'h0;
		push <= 1'b0;
	endtask
	task automatic done(input string nm);
		$display("Test %s finished", nm);
	endtask
	task automatic summarize;
		$display("Comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		summarize;
	end

	initial begin
		seed = 32'h7f038a2b;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_chk(OFF_IDENT, ident_val(1'b0, 3'h0, 1'b0), "ident reset");
		rd_chk(OFF_LINESTA, RST_LINESTA, "status reset");
		rd_chk(OFF_ENABLE, RST_ZERO, "enable reset");
		`CHK("irq idle", 1'b0, irq)
		done("reset");
		rb = 8'($random(seed));
		dv = 16'($random(seed));
		wr_reg(OFF_SCRATCH, rb);
		rd_chk(OFF_SCRATCH, rb, "scratch");
		wr_reg(OFF_LINECTL, 8'h80);
		wr_reg(OFF_DATA, dv[7:0]);
		wr_reg(OFF_ENABLE, dv[15:8]);
		rd_chk(OFF_DATA, dv[7:0], "divisor low");
		rd_chk(OFF_ENABLE, dv[15:8], "divisor high");
		`CHK("divisor", dv, divisor)
		`CHK("line control", 8'h80, line_control)
		wr_reg(OFF_LINECTL, 8'h00);
		rd_chk(OFF_ENABLE, RST_ZERO, "enable kept");
		rd_chk(8'h2c, 8'h00, "unmapped");
		wr_reg(OFF_MODEMCT, rb);
		rd_chk(OFF_MODEMCT, {5'h00, rb[2:0]}, "modem control");
		`CHK("modem control out", rb[2:0], modem_control)
		wr_reg(OFF_PORTEN, 8'hff);
		rd_chk(OFF_PORTEN, 8'h01, "port enable");
		`CHK("port enable out", 1'b1, port_en)
		done("registers");
		// A masked error still lands in line status
		pulse(4'h1, 1'b0, 8'h00);
		idle(3);
		rd_chk(OFF_IDENT, 8'h01, "masked ident");
		`CHK("irq masked", 1'b0, irq)
		rd_chk(OFF_LINESTA, 8'h62, "masked status");
		wr_reg(OFF_ENABLE, 8'h04);
		for (int i = 0; i < 4; i++) begin
			pulse(4'(1 << i), 1'b0, 8'h00);
			idle(3);
			`CHK("irq line", 1'b1, irq)
			rd_chk(OFF_IDENT, ident_val(1'b0, CODE_LINE, 1'b1), "line code");
			rd_chk(OFF_LINESTA, 8'h60 | 8'(2 << i), "error bit");
			rd_chk(OFF_IDENT, 8'h01, "line cleared");
		end
		done("line status");
		wr_reg(OFF_ENABLE, 8'h06);
		rb = 8'($random(seed));
		wr_reg(OFF_DATA, rb);
		idle(10);
		`CHK("holding byte", rb, tx_data)
		`CHK("irq empty", 1'b1, irq)
		wr_reg(OFF_DATA, ~rb);
		idle(2);
		`CHK("irq reloaded", 1'b0, irq)
		idle(10);
		pulse(4'h2, 1'b0, 8'h00);
		idle(3);
		rd_chk(OFF_IDENT, ident_val(1'b0, CODE_LINE, 1'b1), "priority");
		rd_chk(OFF_LINESTA, 8'h64, "parity bit");
		rd_chk(OFF_IDENT, ident_val(1'b0, CODE_TXEMPTY, 1'b1), "empty code");
		rd_chk(OFF_IDENT, 8'h01, "empty cleared");
		done("transmit empty");
		wr_reg(OFF_ENABLE, 8'h08);
		@(posedge clk);
		pins <= 4'h1;
		idle(8);
		`CHK("irq modem", 1'b1, irq)
		rd_chk(OFF_IDENT, ident_val(1'b0, CODE_MODEM, 1'b1), "modem code");
		rd_chk(OFF_MODEMST, 8'h11, "modem status");
		rd_chk(OFF_IDENT, 8'h01, "modem cleared");
		done("modem");
		wr_reg(OFF_ENABLE, 8'h01);
		wr_reg(OFF_IDENT, 8'h41);
		#1;
		`CHK("fifo clear", 2'b11, {tx_clr, rx_clr})
		idle(2);
		`CHK("fifo mode", 1'b1, fifo_mode)
		rb = 8'($random(seed));
		pulse(4'h0, 1'b1, rb);
		idle(40);
		rd_chk(OFF_IDENT, ident_val(1'b1, CODE_TIMEOUT, 1'b1), "time-out");
		rd_chk(OFF_DATA, rb, "fifo byte");
		rd_chk(OFF_IDENT, 8'hc1, "time-out cleared");
		for (int i = 0; i < 4; i++) begin
			pulse(4'h0, 1'b1, 8'(i));
			idle(1);
			`CHK("trigger four", i == 3, irq)
		end
		wr_reg(OFF_IDENT, 8'h00);
		idle(3);
		rd_chk(OFF_IDENT, 8'h01, "fifo off");
		done("fifo");
		rb = 8'($random(seed));
		pulse(4'h0, 1'b1, rb);
		idle(2);
		rd_chk(OFF_IDENT, ident_val(1'b0, CODE_RXDATA, 1'b1), "data code");
		rd_chk(OFF_DATA, rb, "received byte");
		idle(2);
		rd_chk(OFF_IDENT, 8'h01, "data cleared");
		done("received data");
		summarize;
	end
endmodule // tb_top
